// ---- eeim_map.svh ----
`ifndef EEIM_MAP_SVH
`define EEIM_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define EEIM_OFS_FIFO_TRIG 12'h354
`define EEIM_OFS_TX_LO 12'h358
`define EEIM_OFS_TX_MID 12'h35C
`define EEIM_OFS_TX_HI 12'h360
`define EEIM_OFS_TX_CTL 12'h364
`define EEIM_OFS_RX_LO 12'h368
`define EEIM_OFS_RX_MID 12'h36C
`define EEIM_OFS_RX_HI 12'h370
`define EEIM_OFS_RX_CTL 12'h374
`define EEIM_OFS_PCS_TRIG 12'h37C
`define EEIM_OFS_LANE0 12'h380
`define EEIM_OFS_LANE1 12'h384
`define EEIM_OFS_LANE2 12'h388
`define EEIM_OFS_LANE3 12'h38C
// ****************************************
// field widths and reset value
// ****************************************
`define EEIM_HI_W 8
`define EEIM_CTL_W 13
`define EEIM_LANE_W 28
`define EEIM_FIFO_TRIG_W 4
`define EEIM_PCS_TRIG_W 6
`define EEIM_RESET_VAL 32'h00000000
`endif

// ---- eeim_pkg.sv ----
// ****************************************
// shared types
// ****************************************
package eeim_pkg;
    // bus slave phase
    typedef enum logic [1:0] {EEIM_IDLE, EEIM_ANSWER} eeim_bus_state_type;
endpackage

// ---- eeim_inject.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// one-shot xor corruption of a write word
// ****************************************
module eeim_inject #(
    parameter int WIDTH = 72
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic arm, // trigger bit currently set
    input wire logic wr_en, // memory write strobe
    input wire logic [WIDTH-1:0] wr_data, // clean write word
    input wire logic [WIDTH-1:0] mask, // corruption mask
    output logic [WIDTH-1:0] wr_data_out, // possibly corrupted word
    output logic wr_en_out, // delayed write strobe
    output logic done // high when this edge corrupts a word
);
    logic [WIDTH-1:0] next_wr_data_out;
    logic next_wr_en_out;
    // a zero-width word has nothing to corrupt
    if (WIDTH < 1) begin : g_bad_width
        $error("injector width must be positive");
    end
    // data is registered so the corrupted word leaves a flip-flop
    always_comb begin
        next_wr_en_out = wr_en;
        // not registered: the trigger must clear at this same edge
        done = arm && wr_en;
        // ones flip bits, zeros pass them
        next_wr_data_out = (arm && wr_en) ? (wr_data ^ mask) : wr_data;
    end
    // registers only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_data_out <= '0;
            wr_en_out <= 1'b0;
        end else begin
            wr_data_out <= next_wr_data_out;
            wr_en_out <= next_wr_en_out;
        end
    end
endmodule
`default_nettype wire

// ---- eeim_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "eeim_map.svh"
// ****************************************
// ecc error injection mask block
// ****************************************
module eeim_top #(
    parameter bit ECC_ENABLE = 1'b1, // protected memories built
    parameter bit MAC_PRESENT = 1'b1, // mac instantiated
    parameter int DATA_W = 72, // fifo data plus check width
    parameter int RATE_DATA_W = 72, // rate fifo data width
    parameter int RATE_CTL_W = 24 // rate fifo control width
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // register slave
    input wire logic [11:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // tx fifo write port
    input wire logic TX_DATA_WR,
    input wire logic [DATA_W-1:0] TX_DATA_IN,
    output logic TX_DATA_WR_OUT,
    output logic [DATA_W-1:0] TX_DATA_OUT,
    input wire logic TX_CTL_WR,
    input wire logic [`EEIM_CTL_W-1:0] TX_CTL_IN,
    output logic TX_CTL_WR_OUT,
    output logic [`EEIM_CTL_W-1:0] TX_CTL_OUT,
    // rx fifo write port
    input wire logic RX_DATA_WR,
    input wire logic [DATA_W-1:0] RX_DATA_IN,
    output logic RX_DATA_WR_OUT,
    output logic [DATA_W-1:0] RX_DATA_OUT,
    input wire logic RX_CTL_WR,
    input wire logic [`EEIM_CTL_W-1:0] RX_CTL_IN,
    output logic RX_CTL_WR_OUT,
    output logic [`EEIM_CTL_W-1:0] RX_CTL_OUT,
    // deskew lanes, lane n in slice n
    input wire logic [3:0] LANE_WR,
    input wire logic [4*`EEIM_LANE_W-1:0] LANE_IN,
    output logic [3:0] LANE_WR_OUT,
    output logic [4*`EEIM_LANE_W-1:0] LANE_OUT,
    // rate-matching memory: strobes and done from that logic
    output logic RATE_DATA_INJECT,
    output logic RATE_CTL_INJECT,
    input wire logic RATE_DATA_DONE,
    input wire logic RATE_CTL_DONE
);
    // ****************************************
    // elaboration checks
    // ****************************************
    // the three mask words tile exactly 72 bits
    if (DATA_W != 72) begin : g_bad_data_w
        $error("fifo width must be 72");
    end
    // rate widths only size the far memories, zero makes no sense
    if (RATE_DATA_W < 1 || RATE_CTL_W < 1) begin : g_bad_rate_w
        $error("rate widths must be positive");
    end
    // registers built only with ecc and mac
    localparam bit PRESENT = ECC_ENABLE && MAC_PRESENT;

    // ****************************************
    // mask and trigger state
    // ****************************************
    logic [31:0] tx_fifo_data_mask_lo; // bits 31:0
    logic [31:0] tx_fifo_data_mask_mid; // bits 63:32
    logic [`EEIM_HI_W-1:0] tx_fifo_data_mask_hi; // bits 71:64
    logic [`EEIM_CTL_W-1:0] tx_fifo_control_mask;
    logic [31:0] rx_fifo_data_mask_lo;
    logic [31:0] rx_fifo_data_mask_mid;
    logic [`EEIM_HI_W-1:0] rx_fifo_data_mask_hi;
    logic [`EEIM_CTL_W-1:0] rx_fifo_control_mask;
    logic [4*`EEIM_LANE_W-1:0] lane_mask; // lanes 0..3 packed
    logic [`EEIM_FIFO_TRIG_W-1:0] fifo_injection_trigger;
    logic [`EEIM_PCS_TRIG_W-1:0] pcs_injection_trigger;
    logic [31:0] next_tx_lo, next_tx_mid, next_rx_lo, next_rx_mid;
    logic [`EEIM_HI_W-1:0] next_tx_hi, next_rx_hi;
    logic [`EEIM_CTL_W-1:0] next_tx_ctl, next_rx_ctl;
    logic [4*`EEIM_LANE_W-1:0] next_lane_mask;
    logic [`EEIM_FIFO_TRIG_W-1:0] next_fifo_trig;
    logic [`EEIM_PCS_TRIG_W-1:0] next_pcs_trig;
    // bus state
    eeim_pkg::eeim_bus_state_type bus_state, next_bus_state;
    logic [31:0] next_readdata;
    logic [31:0] write_word; // merged write value
    logic [31:0] read_word; // decoded read value
    logic wr_hit; // write accepted this cycle
    // injection taken at this edge, from the injectors; combinational,
    // so a trigger clears at the edge of its own write and a strobe in
    // the next cycle already passes clean
    logic [3:0] fifo_done;
    logic [3:0] lane_done;

    // byte-lane merge of a write with the old value
    // trigger words skip it: written ones set whatever the enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return res;
    endfunction

    // address match used by read and write decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return PRESENT && (a == ofs);
    endfunction

    // ****************************************
    // bus slave
    // ****************************************
    // one wait cycle per access, answer at second edge
    // fixed latency trades a cycle per access for a trivial decode
    always_comb begin
        next_bus_state = bus_state;
        wr_hit = 1'b0;
        AVS_WAITREQUEST = 1'b1;
        case (bus_state)
            eeim_pkg::EEIM_IDLE: begin
                if (AVS_READ || AVS_WRITE) begin
                    next_bus_state = eeim_pkg::EEIM_ANSWER;
                end
            end
            eeim_pkg::EEIM_ANSWER: begin
                // waitrequest falls; request is taken at this edge
                AVS_WAITREQUEST = 1'b0;
                wr_hit = AVS_WRITE;
                next_bus_state = eeim_pkg::EEIM_IDLE;
            end
            default: begin
                next_bus_state = eeim_pkg::EEIM_IDLE;
            end
        endcase
    end

    // read decode; unmapped and reserved bits read zero
    // hit() folds in the build option: a pcs-only build reads zero
    always_comb begin
        read_word = 32'h00000000;
        if (hit(AVS_ADDRESS, `EEIM_OFS_FIFO_TRIG)) begin
            read_word[`EEIM_FIFO_TRIG_W-1:0] = fifo_injection_trigger;
        end else if (hit(AVS_ADDRESS, `EEIM_OFS_TX_LO)) begin
            read_word = tx_fifo_data_mask_lo;
        end else if (hit(AVS_ADDRESS, `EEIM_OFS_TX_MID)) begin
            read_word = tx_fifo_data_mask_mid;
        end else if (hit(AVS_ADDRESS, `EEIM_OFS_TX_HI)) begin
            read_word[`EEIM_HI_W-1:0] = tx_fifo_data_mask_hi;
        end else if (hit(AVS_ADDRESS, `EEIM_OFS_TX_CTL)) begin
            read_word[`EEIM_CTL_W-1:0] = tx_fifo_control_mask;
        end else if (hit(AVS_ADDRESS, `EEIM_OFS_RX_LO)) begin
            read_word = rx_fifo_data_mask_lo;
        end else if (hit(AVS_ADDRESS, `EEIM_OFS_RX_MID)) begin
            read_word = rx_fifo_data_mask_mid;
        end else if (hit(AVS_ADDRESS, `EEIM_OFS_RX_HI)) begin
            read_word[`EEIM_HI_W-1:0] = rx_fifo_data_mask_hi;
        end else if (hit(AVS_ADDRESS, `EEIM_OFS_RX_CTL)) begin
            read_word[`EEIM_CTL_W-1:0] = rx_fifo_control_mask;
        end else if (hit(AVS_ADDRESS, `EEIM_OFS_PCS_TRIG)) begin
            read_word[`EEIM_PCS_TRIG_W-1:0] = pcs_injection_trigger;
        end else begin
            for (int l = 0; l < 4; l++) begin
                if (hit(AVS_ADDRESS, `EEIM_OFS_LANE0 + 12'(4 * l))) begin
                    read_word[`EEIM_LANE_W-1:0] = lane_mask[l*`EEIM_LANE_W +: `EEIM_LANE_W];
                end
            end
        end
        // data out of a flip-flop, loaded in the wait cycle
        next_readdata = (bus_state == eeim_pkg::EEIM_IDLE && AVS_READ) ? read_word
                                                                        : AVS_READDATA;
    end

    assign write_word = merge(read_word, AVS_WRITEDATA, AVS_BYTEENABLE);

    // ****************************************
    // mask and trigger next values
    // ****************************************
    always_comb begin
        next_tx_lo = tx_fifo_data_mask_lo;
        next_tx_mid = tx_fifo_data_mask_mid;
        next_tx_hi = tx_fifo_data_mask_hi;
        next_tx_ctl = tx_fifo_control_mask;
        next_rx_lo = rx_fifo_data_mask_lo;
        next_rx_mid = rx_fifo_data_mask_mid;
        next_rx_hi = rx_fifo_data_mask_hi;
        next_rx_ctl = rx_fifo_control_mask;
        next_lane_mask = lane_mask;
        // hardware clears a trigger once its error went
        // rate bits clear on the far logic's own done pulse
        next_fifo_trig = fifo_injection_trigger & ~fifo_done;
        next_pcs_trig = pcs_injection_trigger
                        & ~{RATE_CTL_DONE, RATE_DATA_DONE, lane_done};
        if (wr_hit) begin
            // reserved bits are dropped by the narrow slices
            if (hit(AVS_ADDRESS, `EEIM_OFS_TX_LO)) next_tx_lo = write_word;
            if (hit(AVS_ADDRESS, `EEIM_OFS_TX_MID)) next_tx_mid = write_word;
            if (hit(AVS_ADDRESS, `EEIM_OFS_TX_HI)) begin
                next_tx_hi = write_word[`EEIM_HI_W-1:0];
            end
            if (hit(AVS_ADDRESS, `EEIM_OFS_TX_CTL)) begin
                next_tx_ctl = write_word[`EEIM_CTL_W-1:0];
            end
            if (hit(AVS_ADDRESS, `EEIM_OFS_RX_LO)) next_rx_lo = write_word;
            if (hit(AVS_ADDRESS, `EEIM_OFS_RX_MID)) next_rx_mid = write_word;
            if (hit(AVS_ADDRESS, `EEIM_OFS_RX_HI)) begin
                next_rx_hi = write_word[`EEIM_HI_W-1:0];
            end
            if (hit(AVS_ADDRESS, `EEIM_OFS_RX_CTL)) begin
                next_rx_ctl = write_word[`EEIM_CTL_W-1:0];
            end
            for (int l = 0; l < 4; l++) begin
                if (hit(AVS_ADDRESS, `EEIM_OFS_LANE0 + 12'(4 * l))) begin
                    // lanes 0,1 then 2,3 follow
                    next_lane_mask[l*`EEIM_LANE_W +: `EEIM_LANE_W] =
                        write_word[`EEIM_LANE_W-1:0];
                end
            end
            // ones arm, zeros never cancel; a same-cycle done still clears
            // only the bits it fired, a fresh one written now stays set
            if (hit(AVS_ADDRESS, `EEIM_OFS_FIFO_TRIG)) begin
                next_fifo_trig = next_fifo_trig
                                 | AVS_WRITEDATA[`EEIM_FIFO_TRIG_W-1:0];
            end
            if (hit(AVS_ADDRESS, `EEIM_OFS_PCS_TRIG)) begin
                next_pcs_trig = next_pcs_trig | AVS_WRITEDATA[`EEIM_PCS_TRIG_W-1:0];
            end
        end
    end

    // registers only; everything resets to zero
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            bus_state <= eeim_pkg::EEIM_IDLE;
            AVS_READDATA <= `EEIM_RESET_VAL;
            tx_fifo_data_mask_lo <= `EEIM_RESET_VAL;
            tx_fifo_data_mask_mid <= `EEIM_RESET_VAL;
            tx_fifo_data_mask_hi <= '0;
            tx_fifo_control_mask <= '0;
            rx_fifo_data_mask_lo <= `EEIM_RESET_VAL;
            rx_fifo_data_mask_mid <= `EEIM_RESET_VAL;
            rx_fifo_data_mask_hi <= '0;
            rx_fifo_control_mask <= '0;
            lane_mask <= '0;
            fifo_injection_trigger <= '0;
            pcs_injection_trigger <= '0;
        end else begin
            bus_state <= next_bus_state;
            AVS_READDATA <= next_readdata;
            tx_fifo_data_mask_lo <= next_tx_lo;
            tx_fifo_data_mask_mid <= next_tx_mid;
            tx_fifo_data_mask_hi <= next_tx_hi;
            tx_fifo_control_mask <= next_tx_ctl;
            rx_fifo_data_mask_lo <= next_rx_lo;
            rx_fifo_data_mask_mid <= next_rx_mid;
            rx_fifo_data_mask_hi <= next_rx_hi;
            rx_fifo_control_mask <= next_rx_ctl;
            lane_mask <= next_lane_mask;
            fifo_injection_trigger <= next_fifo_trig;
            pcs_injection_trigger <= next_pcs_trig;
        end
    end

    // ****************************************
    // injectors on the fifo and deskew lane write paths; the rate memory gets strobes only
    // ****************************************
    // each injector delays its strobe and word by exactly one cycle
    // tx data word: three mask words side by side
    eeim_inject #(.WIDTH(DATA_W)) u_tx_data (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .arm(fifo_injection_trigger[0]),
        .wr_en(TX_DATA_WR),
        .wr_data(TX_DATA_IN),
        .mask({tx_fifo_data_mask_hi, tx_fifo_data_mask_mid, tx_fifo_data_mask_lo}),
        .wr_data_out(TX_DATA_OUT),
        .wr_en_out(TX_DATA_WR_OUT),
        .done(fifo_done[0])
    );
    eeim_inject #(.WIDTH(`EEIM_CTL_W)) u_tx_ctl (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .arm(fifo_injection_trigger[1]),
        .wr_en(TX_CTL_WR),
        .wr_data(TX_CTL_IN),
        .mask(tx_fifo_control_mask),
        .wr_data_out(TX_CTL_OUT),
        .wr_en_out(TX_CTL_WR_OUT),
        .done(fifo_done[1])
    );
    // rx paths mirror tx
    eeim_inject #(.WIDTH(DATA_W)) u_rx_data (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .arm(fifo_injection_trigger[2]),
        .wr_en(RX_DATA_WR),
        .wr_data(RX_DATA_IN),
        .mask({rx_fifo_data_mask_hi, rx_fifo_data_mask_mid, rx_fifo_data_mask_lo}),
        .wr_data_out(RX_DATA_OUT),
        .wr_en_out(RX_DATA_WR_OUT),
        .done(fifo_done[2])
    );
    eeim_inject #(.WIDTH(`EEIM_CTL_W)) u_rx_ctl (
        .clk(CLK_SYS),
        .reset_n(RESET_N),
        .arm(fifo_injection_trigger[3]),
        .wr_en(RX_CTL_WR),
        .wr_data(RX_CTL_IN),
        .mask(rx_fifo_control_mask),
        .wr_data_out(RX_CTL_OUT),
        .wr_en_out(RX_CTL_WR_OUT),
        .done(fifo_done[3])
    );
    // one injector per deskew lane, armed by its channel bit
    for (genvar g = 0; g < 4; g++) begin : g_lane
        eeim_inject #(.WIDTH(`EEIM_LANE_W)) u_lane (
            .clk(CLK_SYS),
            .reset_n(RESET_N),
            .arm(pcs_injection_trigger[g]),
            .wr_en(LANE_WR[g]),
            .wr_data(LANE_IN[g*`EEIM_LANE_W +: `EEIM_LANE_W]),
            .mask(lane_mask[g*`EEIM_LANE_W +: `EEIM_LANE_W]),
            .wr_data_out(LANE_OUT[g*`EEIM_LANE_W +: `EEIM_LANE_W]),
            .wr_en_out(LANE_WR_OUT[g]),
            .done(lane_done[g])
        );
    end

    // rate memory masks live elsewhere; only the strobes go out
    // limitation: a strobe stays up until that logic reports done
    assign RATE_DATA_INJECT = pcs_injection_trigger[4];
    assign RATE_CTL_INJECT = pcs_injection_trigger[5];
endmodule
`default_nettype wire

// ---- eeim_top_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "eeim_map.svh"
// ****************************************
// port-level checker for the injection block
// ****************************************
module eeim_top_sva (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic [11:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic TX_DATA_WR,
    input wire logic TX_CTL_WR,
    input wire logic RX_DATA_WR,
    input wire logic RX_CTL_WR,
    input wire logic [3:0] LANE_WR,
    input wire logic TX_DATA_WR_OUT,
    input wire logic TX_CTL_WR_OUT,
    input wire logic RX_DATA_WR_OUT,
    input wire logic RX_CTL_WR_OUT,
    input wire logic [3:0] LANE_WR_OUT,
    input wire logic RATE_DATA_INJECT,
    input wire logic RATE_CTL_INJECT,
    input wire logic RATE_DATA_DONE,
    input wire logic RATE_CTL_DONE
);
    // one clock domain, so one default clock and reset
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    a_bus_one_wait: assert property (
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus answer not one cycle after request");
    a_bus_idle_wait: assert property (
        !AVS_READ && !AVS_WRITE |-> AVS_WAITREQUEST)
        else $error("waitrequest low with no request");
    a_read_data_hold: assert property (
        !AVS_READ |=> $stable(AVS_READDATA))
        else $error("read data moved without a read");
    a_strobe_one_late: assert property (
        1'b1 |=> {TX_DATA_WR_OUT, TX_CTL_WR_OUT, RX_DATA_WR_OUT, RX_CTL_WR_OUT, LANE_WR_OUT}
        == $past({TX_DATA_WR, TX_CTL_WR, RX_DATA_WR, RX_CTL_WR, LANE_WR}))
        else $error("write strobe not delayed by one cycle");
    a_rate_data_set: assert property (
        $rose(RATE_DATA_INJECT) |-> $past(AVS_WRITE) && $past(AVS_WRITEDATA[4])
        && $past(AVS_ADDRESS) == `EEIM_OFS_PCS_TRIG)
        else $error("rate data strobe rose without a trigger write");
    a_rate_ctl_set: assert property (
        $rose(RATE_CTL_INJECT) |-> $past(AVS_WRITE) && $past(AVS_WRITEDATA[5])
        && $past(AVS_ADDRESS) == `EEIM_OFS_PCS_TRIG)
        else $error("rate control strobe rose without a trigger write");
    a_rate_data_clear: assert property (
        $fell(RATE_DATA_INJECT) |-> $past(RATE_DATA_DONE) || $past(RATE_DATA_DONE, 2))
        else $error("rate data strobe fell without done");
    a_rate_ctl_clear: assert property (
        $fell(RATE_CTL_INJECT) |-> $past(RATE_CTL_DONE) || $past(RATE_CTL_DONE, 2))
        else $error("rate control strobe fell without done");
    a_rate_done_bound: assert property (
        RATE_DATA_DONE && !AVS_WRITE |-> ##[1:2] !RATE_DATA_INJECT)
        else $error("rate data strobe held after done");
endmodule
bind eeim_top eeim_top_sva u_sva (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .TX_DATA_WR(TX_DATA_WR), .TX_CTL_WR(TX_CTL_WR),
    .RX_DATA_WR(RX_DATA_WR), .RX_CTL_WR(RX_CTL_WR), .LANE_WR(LANE_WR),
    .TX_DATA_WR_OUT(TX_DATA_WR_OUT), .TX_CTL_WR_OUT(TX_CTL_WR_OUT),
    .RX_DATA_WR_OUT(RX_DATA_WR_OUT), .RX_CTL_WR_OUT(RX_CTL_WR_OUT),
    .LANE_WR_OUT(LANE_WR_OUT), .RATE_DATA_INJECT(RATE_DATA_INJECT),
    .RATE_CTL_INJECT(RATE_CTL_INJECT), .RATE_DATA_DONE(RATE_DATA_DONE),
    .RATE_CTL_DONE(RATE_CTL_DONE));
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "eeim_map.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", nm, (e), (g)); end end
// ****************************************
// self-checking bench for the injection block
// ****************************************
module tb_top;
    logic clk_sys, reset_n, rd, wr, waitreq, rate_d_inj, rate_c_inj, rate_d_done, rate_c_done;
    logic [11:0] address;
    logic [31:0] wdata, rdata;
    logic [3:0] be, lane_wr, lane_wr_o;
    logic tx_wr, tx_wr_o, txc_wr, txc_wr_o, rx_wr, rx_wr_o, rxc_wr, rxc_wr_o;
    logic [71:0] tx_in, tx_out, rx_in, rx_out; // fifo data plus check
    logic [12:0] txc_in, txc_out, rxc_in, rxc_out; // fifo control plus check
    logic [111:0] lane_in, lane_out; // four 28-bit lanes
    int mismatches, checks;
    // mask registers in table order, their writable bits and test patterns
    logic [11:0] map [12] = '{`EEIM_OFS_TX_LO, `EEIM_OFS_TX_MID, `EEIM_OFS_TX_HI,
        `EEIM_OFS_TX_CTL, `EEIM_OFS_RX_LO, `EEIM_OFS_RX_MID, `EEIM_OFS_RX_HI, `EEIM_OFS_RX_CTL,
        `EEIM_OFS_LANE0, `EEIM_OFS_LANE1, `EEIM_OFS_LANE2, `EEIM_OFS_LANE3};
    logic [31:0] full [12] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h000000FF, 32'h00001FFF,
        32'hFFFFFFFF, 32'hFFFFFFFF, 32'h000000FF, 32'h00001FFF,
        32'h0FFFFFFF, 32'h0FFFFFFF, 32'h0FFFFFFF, 32'h0FFFFFFF};
    // upper ones in the patterns land on reserved bits and must be dropped
    logic [31:0] pat [12] = '{32'h0F0F0F01, 32'h80000002, 32'hFFFFFF81, 32'hFFFF1003,
        32'h12345678, 32'h9ABCDEF0, 32'h0000007E, 32'h00000AAA,
        32'hF1234567, 32'hE89ABCDE, 32'hD0F0F0F0, 32'hC0000001};
    eeim_top DUT (.CLK_SYS(clk_sys), .RESET_N(reset_n), .AVS_ADDRESS(address),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .TX_DATA_WR(tx_wr),
        .TX_DATA_IN(tx_in), .TX_DATA_WR_OUT(tx_wr_o), .TX_DATA_OUT(tx_out),
        .TX_CTL_WR(txc_wr), .TX_CTL_IN(txc_in), .TX_CTL_WR_OUT(txc_wr_o), .TX_CTL_OUT(txc_out),
        .RX_DATA_WR(rx_wr), .RX_DATA_IN(rx_in), .RX_DATA_WR_OUT(rx_wr_o), .RX_DATA_OUT(rx_out),
        .RX_CTL_WR(rxc_wr), .RX_CTL_IN(rxc_in), .RX_CTL_WR_OUT(rxc_wr_o), .RX_CTL_OUT(rxc_out),
        .LANE_WR(lane_wr), .LANE_IN(lane_in), .LANE_WR_OUT(lane_wr_o), .LANE_OUT(lane_out),
        .RATE_DATA_INJECT(rate_d_inj), .RATE_CTL_INJECT(rate_c_inj),
        .RATE_DATA_DONE(rate_d_done), .RATE_CTL_DONE(rate_c_done));
    // 10 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // ****************************************
    // bus and stimulus helpers
    // ****************************************
    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] b, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        rd <= !w;
        wr <= w;
        address <= a;
        wdata <= d;
        be <= b;
        #1;
        while (waitreq !== 1'b0 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        `CHK("bus answer", 1'b1, n < 20)
        // waitrequest is low into this edge: write lands, data taken here
        @(posedge clk_sys);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        #1;
    endtask
    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask
    task automatic rdq(input logic [11:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, 4'hF, q);
    endtask
    // one write strobe on chosen ports, outputs settled on return
    task automatic pulse(input logic f, input logic [3:0] l);
        @(posedge clk_sys);
        {tx_wr, txc_wr, rx_wr, rxc_wr} <= {4{f}};
        lane_wr <= l;
        @(posedge clk_sys);
        {tx_wr, txc_wr, rx_wr, rxc_wr} <= 4'h0;
        lane_wr <= 4'h0;
        #1;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        logic [31:0] q;
        for (int i = 0; i < 12; i++) begin
            rdq(map[i], q);
            `CHK("mask reset", 32'h0, q)
            wr32(map[i], 32'hFFFFFFFF);
            rdq(map[i], q);
            `CHK("mask bits", full[i], q)
        end
        rdq(`EEIM_OFS_PCS_TRIG, q);
        `CHK("trigger reset", 32'h0, q)
        wr32(12'h378, 32'hFFFFFFFF);
        rdq(12'h378, q);
        `CHK("unmapped", 32'h0, q)
        bus(1'b1, `EEIM_OFS_TX_LO, 32'h12345678, 4'h5, q);
        rdq(`EEIM_OFS_TX_LO, q);
        `CHK("byte merge", 32'hFF34FF78, q)
    endtask
    task automatic t_inject;
        logic [31:0] q;
        for (int i = 0; i < 12; i++) wr32(map[i], pat[i]);
        wr32(`EEIM_OFS_FIFO_TRIG, 32'hFFFFFFFF);
        rdq(`EEIM_OFS_FIFO_TRIG, q);
        `CHK("fifo trigger", 32'h0000000F, q)
        wr32(`EEIM_OFS_PCS_TRIG, 32'h0000000F);
        pulse(1'b1, 4'hF);
        `CHK("tx data", tx_in ^ {8'h81, 32'h80000002, 32'h0F0F0F01}, tx_out)
        `CHK("tx control", txc_in ^ 13'h1003, txc_out)
        `CHK("rx data", rx_in ^ {8'h7E, 32'h9ABCDEF0, 32'h12345678}, rx_out)
        `CHK("rx control", rxc_in ^ 13'h0AAA, rxc_out)
        `CHK("strobes", 8'hFF, {tx_wr_o, txc_wr_o, rx_wr_o, rxc_wr_o, lane_wr_o})
        for (int n = 0; n < 4; n++)
            `CHK("lane", lane_in[28*n+:28] ^ pat[8+n][27:0], lane_out[28*n+:28])
        repeat (2) @(posedge clk_sys);
        rdq(`EEIM_OFS_FIFO_TRIG, q);
        `CHK("fifo trigger cleared", 32'h0, q)
        rdq(`EEIM_OFS_PCS_TRIG, q);
        `CHK("lane trigger cleared", 32'h0, q)
        pulse(1'b1, 4'hF);
        `CHK("clean word", {tx_in, txc_in, rx_in, rxc_in, lane_in},
            {tx_out, txc_out, rx_out, rxc_out, lane_out})
        // two strobes back to back on one trigger: only the first is hit
        wr32(`EEIM_OFS_FIFO_TRIG, 32'h00000001);
        @(posedge clk_sys);
        tx_wr <= 1'b1;
        @(posedge clk_sys);
        #1;
        `CHK("first of two", tx_in ^ {8'h81, 32'h80000002, 32'h0F0F0F01}, tx_out)
        @(posedge clk_sys);
        tx_wr <= 1'b0;
        #1;
        `CHK("second of two", tx_in, tx_out)
    endtask
    task automatic t_rate;
        logic [31:0] q;
        wr32(`EEIM_OFS_PCS_TRIG, 32'h00000030);
        `CHK("rate strobes", 2'b11, {rate_c_inj, rate_d_inj})
        @(posedge clk_sys);
        rate_d_done <= 1'b1;
        @(posedge clk_sys);
        rate_d_done <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("rate data cleared", 2'b10, {rate_c_inj, rate_d_inj})
        rdq(`EEIM_OFS_PCS_TRIG, q);
        `CHK("rate trigger", 32'h00000020, q)
        @(posedge clk_sys);
        rate_c_done <= 1'b1;
        @(posedge clk_sys);
        rate_c_done <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rdq(`EEIM_OFS_PCS_TRIG, q);
        `CHK("rate control cleared", 32'h0, q)
    endtask
    // ****************************************
    // verdict, watchdog and main sequence
    // ****************************************
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // whole run is near 210 cycles; this leaves ample margin
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        stop_test();
    end
    initial begin
        {reset_n, rd, wr, address, wdata, be, lane_wr, rate_d_done, rate_c_done} = '0;
        {tx_wr, txc_wr, rx_wr, rxc_wr, mismatches, checks} = '0;
        tx_in = 72'h5A0123456789ABCDEF;
        rx_in = 72'hA5FEDCBA9876543210;
        txc_in = 13'h0155;
        rxc_in = 13'h1E2A;
        lane_in = {28'h4444444, 28'h3333333, 28'h2222222, 28'h1111111};
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_regs();
        t_inject();
        t_rate();
        stop_test();
    end
endmodule
`default_nettype wire
